// file: logic/task_file_defines.svh
`ifndef TASK_FILE_DEFINES_SVH
`define TASK_FILE_DEFINES_SVH

// ****************************************************************
// Address decode
// ****************************************************************
`define TF_PRI_TASK_BASE 6'h1F
`define TF_PRI_CTRL_BASE 6'h3F
`define TF_SEC_TASK_BASE 6'h17
`define TF_SEC_CTRL_BASE 6'h37
`define TF_CTRL_LOW_HI 3'h3
`define TF_IDE_CTRL_HI 2'h3

// ****************************************************************
// Task file offsets
// ****************************************************************
`define TF_OFS_DATA 3'h0
`define TF_OFS_ERR_FEAT 3'h1
`define TF_OFS_COUNT 3'h2
`define TF_OFS_SECTOR 3'h3
`define TF_OFS_TRACK_LO 3'h4
`define TF_OFS_TRACK_HI 3'h5
`define TF_OFS_UNIT_HEAD 3'h6
`define TF_OFS_STAT_CMD 3'h7
`define TF_OFS_ALT_CTRL 3'h6
`define TF_OFS_DRV_ADDR 3'h7

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define ERR_LIVE_MASK 8'hD5
`define UH_FIXED_ONES 8'hA0
`define UH_BIT_LBA 6
`define UH_BIT_DRV 4
`define STAT_BIT_BUSY 7
`define RST_COUNT 8'h01
`define RST_UNIT_HEAD 8'hA0
`define RST_BYTE 8'h00
`define COUNT_ZERO_MEANS 9'h100
`define PIN_IDLE 32'hFFFF_FFFF

`endif

// file: logic/task_file_pkg.sv
package task_file_pkg;

    typedef enum logic [1:0] {
        LAYOUT_PRIMARY = 2'b00,
        LAYOUT_SECONDARY = 2'b01,
        LAYOUT_TRUE_IDE = 2'b10
    } layout_type;

    typedef enum logic [1:0] {
        DEC_NONE = 2'b00,
        DEC_TASK = 2'b01,
        DEC_CTRL = 2'b10
    } dec_kind_type;

    typedef struct packed {
        dec_kind_type kind;
        logic [2:0] idx;
    } dec_type;

    // Host side pins; the select and strobe lines are active low, address and data are not
    typedef struct packed {
        logic reg_n;
        logic [10:0] addr;
        logic ce1_n;
        logic ce2_n;
        logic iord_n;
        logic iowr_n;
        logic [15:0] data;
    } host_pins_type;

    typedef struct packed {
        logic bad_block;
        logic uncorrectable;
        logic id_missing;
        logic aborted;
        logic general;
    } err_event_type;

    typedef struct packed {
        logic lba_mode;
        logic [3:0] head;
        logic [15:0] track;
        logic [7:0] sector;
        logic [27:0] address_mode_select;
    } task_addr_type;

endpackage

// file: logic/pin_sync.sv
module pin_sync
    import task_file_pkg::*;
#(
    parameter int W = 32,
    parameter logic [W-1:0] IDLE = '1
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] stable
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } sync_st_type;

    sync_st_type st_q;
    sync_st_type st_d;

    // A bit moves only once stages two and three agree
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.filt = (~(st_q.s2 ^ st_q.s3) & st_q.s2) |
                    ((st_q.s2 ^ st_q.s3) & st_q.filt);
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            st_q <= {IDLE, IDLE, IDLE, IDLE};
        else
            st_q <= st_d;
    end

    assign stable = st_q.filt;

endmodule // pin_sync

// file: logic/word_buffer.sv
module word_buffer #(
    parameter int W = 16
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] count;
    } buf_st_type;

    buf_st_type st_q;
    buf_st_type st_d;
    logic push;
    logic pop;

    assign in_ready = (st_q.count != 2'd2);
    assign out_valid = (st_q.count != 2'd0);
    assign out_data = st_q.mem[st_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = ~st_q.wr;
        end
        if (pop)
            st_d.rd = ~st_q.rd;
        case ({push, pop})
            2'b10: st_d.count = st_q.count + 2'd1;
            2'b01: st_d.count = st_q.count - 2'd1;
            default: st_d.count = st_q.count;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

endmodule // word_buffer

// file: logic/task_file_register_decode.sv
// Function
// R1: Primary layout: 1FH selects task file
// R2: Primary 3FH: alt status/control, drive address
// R3: Secondary layout uses 17H and 37H
// R4: True IDE decodes by the two selects
// R5: Offset 1 error/feature, 7 status/command
// R6: Sixteen-bit data port, word or byte
// R7: Data space overlaps error/feature position
// R8: Host trusts error only when not busy
// R9: Error bits 5, 3, 1 read zero
// R10: Uncorrectable read error sets its flag
// R11: Aborted command sets its flag
// R12: Feature byte is write only
// R13: Count of zero means 256 sectors
// R14: Failed transfer leaves remaining sector count
// R15: Sector count resets to 01H
// R16: Sector number holds starting sector
// R17: Track low/high hold starting track
// R18: Unit/head: fixed ones, mode, unit, head
// R19: Address mode forms 28-bit block address
// R20: Respond only when unit select matches
// R21: Busy high while internal operation runs
// R22: Status read drops level request, alternate not
// R23: Reserved write changes nothing
// R24: Unmatched read leaves bus undriven
`include "task_file_defines.svh"

module task_file_register_decode
    import task_file_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire layout_type layout,
    input wire logic card_number,
    input wire logic byte_mode,
    input wire logic level_irq_mode,
    input wire host_pins_type host_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic host_wait,
    input wire logic core_busy,
    input wire logic [6:0] core_status,
    input wire err_event_type err_event,
    input wire logic irq_event,
    input wire logic count_update,
    input wire logic [7:0] count_remaining,
    input wire logic [15:0] rd_word,
    output logic rd_pop,
    output logic wr_valid,
    output logic [15:0] wr_word,
    input wire logic wr_ready,
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output logic [7:0] feature,
    output logic [8:0] sector_total,
    output task_addr_type task_addr,
    output logic [7:0] device_control,
    output logic irq
);

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic dec_type decode(
        input layout_type lay,
        input host_pins_type p
    );
        dec_type r;
        logic [5:0] tbase;
        logic [5:0] cbase;
        r.kind = DEC_NONE;
        r.idx = p.addr[2:0];
        tbase = (lay == LAYOUT_PRIMARY) ? `TF_PRI_TASK_BASE
                                        : `TF_SEC_TASK_BASE;
        cbase = (lay == LAYOUT_PRIMARY) ? `TF_PRI_CTRL_BASE
                                        : `TF_SEC_CTRL_BASE;
        case (lay)
            LAYOUT_PRIMARY, LAYOUT_SECONDARY:
            begin
                // Address bit 10 plays no part [R1] [R3]
                if (!p.reg_n && p.addr[9:4] == tbase && !p.addr[3])
                    r.kind = DEC_TASK;
                else if (!p.reg_n && p.addr[9:4] == cbase &&
                         p.addr[3:1] == `TF_CTRL_LOW_HI)
                    r.kind = DEC_CTRL; // [R2]
            end
            LAYOUT_TRUE_IDE:
            begin
                if (!p.ce1_n && p.ce2_n)
                    r.kind = DEC_TASK; // [R4]
                else if (p.ce1_n && !p.ce2_n &&
                         p.addr[2:1] == `TF_IDE_CTRL_HI)
                    r.kind = DEC_CTRL; // [R4]
            end
            default: r.kind = DEC_NONE;
        endcase
        return r;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] err;
        logic [7:0] feat;
        logic [7:0] cnt;
        logic [7:0] sec;
        logic [7:0] trk_lo;
        logic [7:0] trk_hi;
        logic [7:0] uh;
        logic [7:0] cmd;
        logic [7:0] ctrl;
        logic irq;
        logic cmd_go;
        logic rd_prev;
        logic wr_prev;
        logic doe;
        logic pair;
        logic pop;
        logic push;
        logic wait_hi;
        dec_type rd_dec;
        logic [15:0] dout;
        logic [7:0] low_byte;
        logic [15:0] push_word;
        logic [8:0] total;
        task_addr_type addr;
    } st_type;

    st_type q, n;
    host_pins_type pins;
    logic buf_ready, rd_fall, rd_rise, wr_rise, selected;
    dec_type dec;
    logic [7:0] wv, stat;

    pin_sync #(.W($bits(host_pins_type)), .IDLE(`PIN_IDLE)) u_sync (
        .mclk(mclk), .arst_n(arst_n), .pins(host_in), .stable(pins)
    );

    // Stalls the host through the wait pin, so no word is dropped
    word_buffer #(.W(16)) u_buf (
        .mclk(mclk), .arst_n(arst_n), .in_valid(q.push),
        .in_data(q.push_word), .in_ready(buf_ready),
        .out_valid(wr_valid), .out_data(wr_word), .out_ready(wr_ready)
    );

    assign rd_fall = q.rd_prev && !pins.iord_n;
    assign rd_rise = !q.rd_prev && pins.iord_n;
    assign wr_rise = !q.wr_prev && pins.iowr_n;
    assign dec = decode(layout, pins);
    assign selected = (q.uh[`UH_BIT_DRV] == card_number); // [R20]
    assign wv = pins.data[7:0];
    // Other bits are meaningless while busy, so they read zero
    assign stat = core_busy ? 8'h80 : {1'b0, core_status}; // [R21]

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        n = q;
        n.cmd_go = 1'b0;
        n.pop = 1'b0;
        n.rd_prev = pins.iord_n;
        n.wr_prev = pins.iowr_n;
        if (q.push && buf_ready)
            n.push = 1'b0;
        if (count_update)
            n.cnt = count_remaining; // [R14]

        // Read cycle: value frozen at the falling strobe
        if (rd_fall)
        begin
            n.rd_dec = dec;
            n.doe = 1'b0; // [R24]
            if (dec.kind != DEC_NONE && selected)
                n.doe = 1'b1; // [R20]
            n.dout = 16'h0000;
            if (dec.kind == DEC_TASK)
            begin
                case (dec.idx)
                    `TF_OFS_DATA:
                    begin
                        // A word read also covers offset one [R7]
                        if (!byte_mode)
                            n.dout = rd_word; // [R6]
                        else
                            n.dout = {8'h00, q.pair ? rd_word[15:8]
                                                    : rd_word[7:0]};
                    end
                    `TF_OFS_ERR_FEAT:
                        n.dout = {8'h00, q.err & `ERR_LIVE_MASK}; // [R5] [R9]
                    `TF_OFS_COUNT: n.dout = {8'h00, q.cnt};
                    `TF_OFS_SECTOR: n.dout = {8'h00, q.sec};
                    `TF_OFS_TRACK_LO: n.dout = {8'h00, q.trk_lo};
                    `TF_OFS_TRACK_HI: n.dout = {8'h00, q.trk_hi};
                    `TF_OFS_UNIT_HEAD: n.dout = {8'h00, q.uh};
                    default: n.dout = {8'h00, stat}; // [R5]
                endcase
            end
            else if (dec.kind == DEC_CTRL)
            begin
                if (dec.idx == `TF_OFS_ALT_CTRL)
                    n.dout = {8'h00, stat};
                else
                    n.dout = {8'h00, 2'b11, ~q.uh[3:0],
                              ~card_number, card_number};
            end
        end
        // End of read: side effects happen once per strobe
        if (rd_rise)
        begin
            n.doe = 1'b0;
            if (q.doe && q.rd_dec.kind == DEC_TASK)
            begin
                if (q.rd_dec.idx == `TF_OFS_DATA)
                begin
                    n.pop = !byte_mode || q.pair; // [R6]
                    n.pair = byte_mode && !q.pair;
                end
                // Alternate status never reaches this clear [R22]
                if (q.rd_dec.idx == `TF_OFS_STAT_CMD && level_irq_mode)
                    n.irq = 1'b0; // [R22]
            end
        end
        // Write cycle: data taken at the rising strobe
        if (wr_rise && dec.kind == DEC_TASK)
        begin
            case (dec.idx)
                `TF_OFS_DATA:
                begin
                    if (selected && !byte_mode)
                    begin
                        n.push_word = pins.data; // [R6]
                        n.push = 1'b1;
                    end
                    else if (selected && !q.pair)
                    begin
                        n.low_byte = wv;
                        n.pair = 1'b1;
                    end
                    else if (selected)
                    begin
                        n.push_word = {wv, q.low_byte}; // [R6]
                        n.push = 1'b1;
                        n.pair = 1'b0;
                    end
                end
                `TF_OFS_ERR_FEAT: n.feat = wv; // [R5] [R12]
                `TF_OFS_COUNT: n.cnt = wv; // [R13]
                `TF_OFS_SECTOR: n.sec = wv; // [R16]
                `TF_OFS_TRACK_LO: n.trk_lo = wv; // [R17]
                `TF_OFS_TRACK_HI: n.trk_hi = wv; // [R17]
                `TF_OFS_UNIT_HEAD: n.uh = wv | `UH_FIXED_ONES; // [R18]
                default:
                begin
                    if (selected)
                    begin
                        n.cmd = wv; // [R5]
                        n.cmd_go = 1'b1;
                        n.err = 8'h00;
                        n.pair = 1'b0;
                    end
                end
            endcase
        end
        else if (wr_rise && dec.kind == DEC_CTRL &&
                 dec.idx == `TF_OFS_ALT_CTRL)
            n.ctrl = wv;
        // A write at the drive address slot falls through untouched [R23]
        // Hardware set wins over any clear in the same cycle
        n.err = n.err | {err_event.bad_block,
                         err_event.uncorrectable, 1'b0, // [R10]
                         err_event.id_missing, 1'b0,
                         err_event.aborted, 1'b0, // [R11]
                         err_event.general};
        if (irq_event)
            n.irq = 1'b1;
        n.wait_hi = n.push || q.push || !buf_ready;
        n.total = (q.cnt == 8'h00) ? `COUNT_ZERO_MEANS
                                   : {1'b0, q.cnt}; // [R13]
        n.addr.lba_mode = q.uh[`UH_BIT_LBA];
        n.addr.head = q.uh[3:0];
        n.addr.track = {q.trk_hi, q.trk_lo};
        n.addr.sector = q.sec;
        n.addr.address_mode_select = q.uh[`UH_BIT_LBA]
                     ? {q.uh[3:0], q.trk_hi, q.trk_lo, q.sec}
                     : 28'h000_0000; // [R19]
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
            q.cnt <= `RST_COUNT; // [R15]
            q.uh <= `RST_UNIT_HEAD;
            q.rd_prev <= 1'b1;
            q.wr_prev <= 1'b1;
            q.total <= {1'b0, `RST_COUNT};
        end
        else
            q <= n;
    end

    assign data_out = q.dout;
    assign data_oe = q.doe;
    assign host_wait = q.wait_hi;
    assign rd_pop = q.pop;
    assign cmd_strobe = q.cmd_go;
    assign cmd_code = q.cmd;
    assign feature = q.feat;
    assign sector_total = q.total;
    assign task_addr = q.addr;
    assign device_control = q.ctrl;
    assign irq = q.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    chk_err_zero_bits: assert property ( // [R9]
        (q.err & ~`ERR_LIVE_MASK) == 8'h00)
        else $error("error register reserved bit set");
    chk_uh_fixed: assert property ( // [R18]
        (q.uh & `UH_FIXED_ONES) == `UH_FIXED_ONES)
        else $error("unit/head fixed ones lost");
    chk_unc_set: assert property ( // [R10]
        err_event.uncorrectable |=> q.err[6])
        else $error("uncorrectable flag not set");
    chk_command_aborted_flag_set: assert property ( // [R11]
        err_event.aborted |=> q.err[2] [*2])
        else $error("aborted flag not held");
    chk_count_total: assert property ( // [R13]
        ##1 sector_total == (($past(q.cnt) == 8'h00) ? 9'h100
                             : {1'b0, $past(q.cnt)}))
        else $error("sector total wrong");
    chk_status_irq: assert property ( // [R22]
        rd_rise && q.doe && q.rd_dec.kind == DEC_TASK &&
        q.rd_dec.idx == `TF_OFS_STAT_CMD && level_irq_mode &&
        !irq_event |=> !irq)
        else $error("status read kept request");
    chk_alt_keeps_irq: assert property ( // [R22]
        rd_rise && q.rd_dec.kind == DEC_CTRL && irq |=> irq)
        else $error("alternate status read dropped request");
    chk_reserved_write: assert property ( // [R23]
        wr_rise && dec.kind == DEC_CTRL && dec.idx == `TF_OFS_DRV_ADDR
        && !count_update && err_event == '0
        |=> $stable(q.cnt) && $stable(q.ctrl) && $stable(q.err)
            && !cmd_strobe)
        else $error("reserved write changed state");
    chk_unmapped_float: assert property ( // [R24]
        rd_fall && dec.kind == DEC_NONE |=> !data_oe)
        else $error("unmapped read drove bus");
    chk_busy_status: assert property ( // [R21]
        rd_fall && dec.kind == DEC_CTRL && dec.idx == `TF_OFS_ALT_CTRL
        && core_busy |=> data_out[7:0] == 8'h80)
        else $error("busy not shown in status");
    chk_cmd_pulse: assert property ( // [R5]
        cmd_strobe |=> !cmd_strobe)
        else $error("command strobe longer than a cycle");
    chk_unit_match: assert property ( // [R20]
        rd_fall && !selected |=> !data_oe)
        else $error("unselected unit drove bus");

endmodule // task_file_register_decode

// file: dv/host_port_model.sv
module host_port_model
    import task_file_pkg::*;
(
    input wire logic mclk,
    input wire logic data_oe,
    input wire logic [15:0] data_out,
    output host_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pins = 32'hFFFF_FFFF;

    // ********************
    // Host cycle
    // ********************
    // Strobe 8 cycles, address held 6 past it: outlasts the pin filter
    task automatic access(
        input logic wr,
        input logic [10:0] a,
        input logic [1:0] ce_n,
        input logic [15:0] wd,
        output logic [15:0] rd,
        output logic oe
    );
        @(negedge mclk);
        pins.reg_n = 1'h0;
        pins.addr = a;
        {pins.ce1_n, pins.ce2_n} = ce_n;
        pins.data = wr ? wd : ~pins.data;
        @(negedge mclk);
        if (wr)
            pins.iowr_n = 1'h0;
        else
            pins.iord_n = 1'h0;
        repeat (8) @(negedge mclk);
        rd = data_oe ? data_out : ~data_out;
        oe = data_oe;
        pins.iowr_n = 1'h1;
        pins.iord_n = 1'h1;
        repeat (6) @(negedge mclk);
        {pins.reg_n, pins.ce1_n, pins.ce2_n} = 3'h7;
        // Released lines must not keep showing the last value
        pins.data = ~pins.data;
    endtask
endmodule // host_port_model

// file: dv/task_file_register_decode_tb_top.sv
module task_file_register_decode_tb_top
    import task_file_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************
    // Signals
    // ********************
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    layout_type layout = LAYOUT_PRIMARY;
    logic card_number = 1'h0;
    logic byte_mode = 1'h0;
    logic level_irq_mode = 1'h0;
    host_pins_type host_in;
    logic [15:0] data_out;
    logic data_oe, host_wait, rd_pop, wr_valid, cmd_strobe, irq;
    logic core_busy = 1'h0;
    logic [6:0] core_status = 7'h50;
    err_event_type err_event = '0;
    logic irq_event = 1'h0;
    logic count_update = 1'h0;
    logic [7:0] count_remaining = 8'h05;
    logic [15:0] rd_word = 16'h1234;
    logic [15:0] wr_word;
    logic wr_ready = 1'h0;
    logic [7:0] cmd_code, feature, device_control, exp_err;
    logic [8:0] sector_total;
    task_addr_type task_addr;
    logic [1:0] ce_sel = 2'h1;
    logic [15:0] rd_v;
    logic oe_v;
    logic [7:0] err_bits [5] = '{8'h01, 8'h04, 8'h10, 8'h40, 8'h80};
    int bad_count = 0;
    int n_compared = 0;
    int cmd_cnt = 0;
    int pop_cnt = 0;
    logic [15:0] wr_q [$];

    always #20 mclk = ~mclk;

    always @(posedge mclk)
    begin
        if (cmd_strobe === 1'h1)
            cmd_cnt++;
        if (rd_pop === 1'h1)
            pop_cnt++;
        if (wr_valid === 1'h1 && wr_ready === 1'h1)
            wr_q.push_back(wr_word);
    end

    task_file_register_decode task_file_register_decode_i (
        .mclk(mclk), .arst_n(arst_n), .layout(layout),
        .card_number(card_number), .byte_mode(byte_mode),
        .level_irq_mode(level_irq_mode), .host_in(host_in),
        .data_out(data_out), .data_oe(data_oe), .host_wait(host_wait),
        .core_busy(core_busy), .core_status(core_status),
        .err_event(err_event), .irq_event(irq_event),
        .count_update(count_update), .count_remaining(count_remaining),
        .rd_word(rd_word), .rd_pop(rd_pop), .wr_valid(wr_valid),
        .wr_word(wr_word), .wr_ready(wr_ready), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code), .feature(feature),
        .sector_total(sector_total), .task_addr(task_addr),
        .device_control(device_control), .irq(irq)
    );

    host_port_model host_port_model_i (
        .mclk(mclk), .data_oe(data_oe), .data_out(data_out),
        .pins(host_in)
    );

    // ********************
    // Tasks
    // ********************
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        host_port_model_i.access(1'h1, a, ce_sel, d, rd_v, oe_v);
    endtask

    task automatic rd(input logic [10:0] a);
        host_port_model_i.access(1'h0, a, ce_sel, 16'h0000, rd_v, oe_v);
    endtask

    task automatic rd_chk(input string what, input logic [10:0] a,
        input logic [7:0] exp);
        rd(a);
        check("drive", 16'h0001, {15'h0000, oe_v});
        check(what, {8'h00, exp}, {8'h00, rd_v[7:0]});
    endtask

    task automatic no_drive(input logic [10:0] a);
        rd(a);
        check("no drive", 16'h0000, {15'h0000, oe_v});
    endtask

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ********************
    // Sequence
    // ********************
    initial
    begin
        repeat (8) @(negedge mclk);
        arst_n = 1'h1;
        rd_chk("count rst", 11'h1F2, 8'h01);
        rd_chk("unit rst", 11'h1F6, 8'hA0);
        rd_chk("status", 11'h1F7, 8'h50);
        $display("test reset done");
        wr(11'h1F3, 16'h005A);
        wr(11'h1F4, 16'h00C3);
        wr(11'h1F5, 16'h003C);
        wr(11'h1F6, 16'h0047);
        rd_chk("sector", 11'h1F3, 8'h5A);
        rd_chk("track lo", 11'h1F4, 8'hC3);
        rd_chk("track hi", 11'h5F5, 8'h3C);
        rd_chk("unit head", 11'h1F6, 8'hE7);
        check("mode", 16'h0001, {15'h0000, task_addr.lba_mode});
        check("lba lo", 16'hC35A, task_addr.address_mode_select[15:0]);
        check("lba hi", 16'h073C, {4'h0, task_addr.address_mode_select[27:16]});
        check("track", 16'h3CC3, task_addr.track);
        check("sector", 16'h005A, {8'h00, task_addr.sector});
        check("head", 16'h0007, {12'h000, task_addr.head});
        $display("test address done");
        wr(11'h1F2, 16'h0000);
        check("total", 16'h0100, {7'h00, sector_total});
        count_update = 1'h1;
        @(negedge mclk);
        count_update = 1'h0;
        rd_chk("remaining", 11'h1F2, 8'h05);
        $display("test count done");
        exp_err = 8'h00;
        for (int i = 4; i >= 0; i--)
        begin
            err_event = err_event_type'(5'h01 << i);
            @(negedge mclk);
            err_event = '0;
            exp_err = exp_err | err_bits[i];
            rd_chk("error", 11'h1F1, exp_err);
        end
        wr(11'h1F1, 16'h009B);
        check("feature", 16'h009B, {8'h00, feature});
        rd_chk("error kept", 11'h1F1, 8'hD5);
        wr(11'h1F7, 16'h00EC);
        check("cmd", 16'h00EC, {8'h00, cmd_code});
        check("cmd pulses", 16'h0001, 16'(cmd_cnt));
        rd_chk("error clr", 11'h1F1, 8'h00);
        $display("test error done");
        level_irq_mode = 1'h1;
        irq_event = 1'h1;
        @(negedge mclk);
        irq_event = 1'h0;
        rd_chk("alt status", 11'h3F6, 8'h50);
        check("irq kept", 16'h0001, {15'h0000, irq});
        rd_chk("status", 11'h1F7, 8'h50);
        check("irq clr", 16'h0000, {15'h0000, irq});
        core_busy = 1'h1;
        rd_chk("busy", 11'h3F6, 8'h80);
        core_busy = 1'h0;
        $display("test status done");
        wr(11'h3F6, 16'h000A);
        check("dev ctrl", 16'h000A, {8'h00, device_control});
        wr(11'h3F7, 16'h00FF);
        rd_chk("drv addr", 11'h3F7, 8'hE2);
        rd_chk("unit kept", 11'h1F6, 8'hE7);
        no_drive(11'h2F2);
        no_drive(11'h1FA);
        card_number = 1'h1;
        no_drive(11'h1F2);
        card_number = 1'h0;
        $display("test decode done");
        rd(11'h1F0);
        check("data rd", 16'h1234, rd_v);
        check("pops", 16'h0001, 16'(pop_cnt));
        wr(11'h1F0, 16'hABCD);
        wr(11'h1F0, 16'h5AA5);
        check("wait full", 16'h0001, {15'h0000, host_wait});
        wr_ready = 1'h1;
        for (int i = 0; i < 20 && wr_q.size() < 2; i++)
            @(negedge mclk);
        if (wr_q.size() < 2)
        begin
            bad_count++;
            $display("BAD write stream expected 2 words seen %0d",
                wr_q.size());
        end
        check("word 0", 16'hABCD, wr_q[0]);
        check("word 1", 16'h5AA5, wr_q[1]);
        check("wait free", 16'h0000, {15'h0000, host_wait});
        byte_mode = 1'h1;
        rd(11'h1F0);
        check("byte lo", 16'h0034, rd_v);
        rd(11'h1F0);
        check("byte hi", 16'h0012, rd_v);
        check("byte pops", 16'h0002, 16'(pop_cnt));
        wr(11'h1F0, 16'h0077);
        wr(11'h1F0, 16'h0066);
        repeat (4) @(negedge mclk);
        check("byte words", 16'h0003, 16'(wr_q.size()));
        check("byte word", 16'h6677, wr_q[wr_q.size() - 1]);
        byte_mode = 1'h0;
        $display("test data done");
        layout = LAYOUT_SECONDARY;
        wr(11'h172, 16'h0007);
        rd_chk("sec count", 11'h172, 8'h07);
        rd_chk("sec alt", 11'h376, 8'h50);
        no_drive(11'h1F2);
        layout = LAYOUT_TRUE_IDE;
        rd_chk("ide count", 11'h002, 8'h07);
        ce_sel = 2'h2;
        rd_chk("ide alt", 11'h006, 8'h50);
        ce_sel = 2'h3;
        no_drive(11'h002);
        $display("test layouts done");
        complete_run();
    end
endmodule // task_file_register_decode_tb_top
